// ### design/stcp_timer.sv
// Purpose: 10-bit compare / timer / edge pwm timer with wishbone registers
// Assumes: classic wishbone slave, one wait state on every access
// Notes: capture and single pulse modes are not provided
`timescale 1ns/1ns

module stcp_timer
	import stcp_pkg::*;
(
	input wire logic clk_i, // system clock
	input wire logic rst_i, // sync reset, high
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // write enable
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	output logic wb_err_o, // unmapped address
	output logic timer_out_o, // timer output pin level
	output logic timer_out_en_o, // pin driven by timer
	output logic match_a_flag_o, // comparator A flag
	output logic match_p_flag_o // comparator P flag
);
	stcp_tick_if tk ();

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [7:0] ctrl0_r, ctrl0_nxt;
	logic [7:0] ctrl1_r, ctrl1_nxt;
	logic [9:0] cmpa_r, cmpa_nxt;
	logic [7:0] clkdiv_r, clkdiv_nxt;
	logic [9:0] cnt_r, cnt_nxt;
	logic flag_a_r, flag_a_nxt;
	logic flag_p_r, flag_p_nxt;
	logic run_d_r, run_d_nxt;
	logic pin_r, pin_nxt;
	logic pin_en_r, pin_en_nxt;
	logic ack_r, ack_nxt;
	logic err_r, err_nxt;
	logic [31:0] rdat_r, rdat_nxt;

	logic run, run_rise;
	logic [1:0] func;
	logic [2:0] pval;
	logic [9:0] pfull;
	stcp_mode_t mode;
	logic req, hit;
	logic set_a, set_p, clr_cnt;
	logic pwm_act;
	logic [9:0] period, duty;

	// decode a register offset; true when mapped
	function automatic logic stcp_mapped(input logic [7:0] adr);
		stcp_mapped = (adr == STCP_CTRL0_OFS) || (adr == STCP_CTRL1_OFS) ||
			(adr == STCP_CMPA_LO_OFS) || (adr == STCP_CMPA_HI_OFS) ||
			(adr == STCP_CNT_LO_OFS) || (adr == STCP_CNT_HI_OFS) ||
			(adr == STCP_FLAGS_OFS) || (adr == STCP_CLKDIV_OFS);
	endfunction : stcp_mapped

	// ----------------------------------------
	// divider and comparators
	// ----------------------------------------
	stcp_clkdiv u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.div_i(clkdiv_r),
		.tk(tk.div)
	);

	stcp_compare u_cmp (
		.tk(tk.cmp)
	);

	assign tk.count = cnt_r;
	assign tk.cmp_a = cmpa_r;
	assign tk.cmp_p = pval;

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	always_comb
	begin
		run = ctrl0_r[STCP_RUN_BIT];
		pval = ctrl0_r[STCP_PVAL_LSB +: 3];
		mode = stcp_mode_t'(ctrl1_r[STCP_MODE_LSB +: 2]);
		func = ctrl1_r[STCP_FUNC_LSB +: 2];
		run_rise = run && !run_d_r;
		pfull = (pval == 3'h0) ? STCP_CNT_MAX : {pval, 7'h00} - 10'h001;
		req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
		hit = stcp_mapped(wb_adr_i);
	end

	// ----------------------------------------
	// counter, matches and flags
	// ----------------------------------------
	always_comb
	begin
		set_a = 1'b0;
		set_p = 1'b0;
		clr_cnt = 1'b0;
		period = 10'h000;
		duty = 10'h000;
		unique case (mode)
			STCP_MODE_PWM:
			begin
				period = (pval == 3'h0) ? STCP_CNT_MAX : {pval, 7'h00};
				duty = cmpa_r;
				if (ctrl1_r[STCP_SWAP_BIT])
				begin
					period = cmpa_r;
					duty = (pval == 3'h0) ? STCP_CNT_MAX : {pval, 7'h00};
				end
				set_a = tk.match_a;
				set_p = tk.match_p;
				if (ctrl1_r[STCP_SWAP_BIT])
					clr_cnt = (cnt_r == cmpa_r - 10'h001) || (cmpa_r == 10'h000);
				else
					clr_cnt = (cnt_r == pfull);
			end
			default:
			begin
				if (ctrl1_r[STCP_CCLR_BIT])
				begin
					set_a = tk.match_a && (cmpa_r != 10'h000);
					clr_cnt = (cmpa_r == 10'h000) ? (cnt_r == STCP_CNT_MAX) :
						tk.match_a;
				end
				else
				begin
					// P clears or wraps, both flags
					set_a = tk.match_a && (cmpa_r != 10'h000);
					set_p = tk.match_p;
					clr_cnt = (cnt_r == pfull);
				end
			end
		endcase
		set_a = set_a && run && tk.tick;
		set_p = set_p && run && tk.tick;
	end

	always_comb
	begin
		cnt_nxt = cnt_r;
		if (run_rise)
			cnt_nxt = 10'h000;
		else if (run && tk.tick)
			cnt_nxt = clr_cnt ? 10'h000 : cnt_r + 10'h001;
		run_d_nxt = run;
		// set wins over clear
		flag_a_nxt = flag_a_r;
		flag_p_nxt = flag_p_r;
		if (req && wb_we_i && wb_sel_i[0] && (wb_adr_i == STCP_FLAGS_OFS))
		begin
			if (wb_dat_i[STCP_FLAG_A_BIT])
				flag_a_nxt = 1'b0;
			if (wb_dat_i[STCP_FLAG_P_BIT])
				flag_p_nxt = 1'b0;
		end
		if (set_a)
			flag_a_nxt = 1'b1;
		if (set_p)
			flag_p_nxt = 1'b1;
	end

	// ----------------------------------------
	// output pin
	// ----------------------------------------
	always_comb
	begin
		pin_nxt = pin_r;
		pin_en_nxt = 1'b0;
		// duty at or above period stays active
		pwm_act = (duty >= period) || (cnt_r < duty);
		unique case (mode)
			STCP_MODE_CMP:
			begin
				pin_en_nxt = 1'b1;
				if (run_rise)
					pin_nxt = ctrl1_r[STCP_OC_BIT];
				else if (set_a)
				begin
					unique case (func)
						STCP_FN_LOW: pin_nxt = 1'b0;
						STCP_FN_HIGH: pin_nxt = 1'b1;
						STCP_FN_TOG: pin_nxt = !pin_r;
						default: pin_nxt = pin_r;
					endcase
				end
			end
			STCP_MODE_PWM:
			begin
				pin_en_nxt = 1'b1;
				unique case (func)
					STCP_FN_NONE: pin_nxt = !ctrl1_r[STCP_OC_BIT];
					STCP_FN_LOW: pin_nxt = ctrl1_r[STCP_OC_BIT];
					STCP_FN_HIGH: pin_nxt = (run && pwm_act) ? ctrl1_r[STCP_OC_BIT] :
						!ctrl1_r[STCP_OC_BIT];
					default: pin_nxt = pin_r;
				endcase
				pin_nxt = pin_nxt ^ ctrl1_r[STCP_POL_BIT];
			end
			default:
			begin
				pin_en_nxt = 1'b0;
				pin_nxt = pin_r;
			end
		endcase
	end

	// ----------------------------------------
	// wishbone slave
	// ----------------------------------------
	always_comb
	begin
		ctrl0_nxt = ctrl0_r;
		ctrl1_nxt = ctrl1_r;
		cmpa_nxt = cmpa_r;
		clkdiv_nxt = clkdiv_r;
		ack_nxt = req && hit;
		err_nxt = req && !hit;
		rdat_nxt = 32'h0000_0000;
		if (req && hit && wb_we_i && wb_sel_i[0])
		begin
			unique case (wb_adr_i)
				STCP_CTRL0_OFS: ctrl0_nxt = wb_dat_i[7:0] & 8'h0f;
				STCP_CTRL1_OFS: ctrl1_nxt = wb_dat_i[7:0];
				STCP_CMPA_LO_OFS: cmpa_nxt[7:0] = wb_dat_i[7:0];
				STCP_CMPA_HI_OFS: cmpa_nxt[9:8] = wb_dat_i[1:0];
				STCP_CLKDIV_OFS: clkdiv_nxt = wb_dat_i[7:0];
				default: ;
			endcase
		end
		if (req && hit && !wb_we_i)
		begin
			unique case (wb_adr_i)
				STCP_CTRL0_OFS: rdat_nxt[7:0] = ctrl0_r;
				STCP_CTRL1_OFS: rdat_nxt[7:0] = ctrl1_r;
				STCP_CMPA_LO_OFS: rdat_nxt[7:0] = cmpa_r[7:0];
				STCP_CMPA_HI_OFS: rdat_nxt[1:0] = cmpa_r[9:8];
				STCP_CNT_LO_OFS: rdat_nxt[7:0] = cnt_r[7:0];
				STCP_CNT_HI_OFS: rdat_nxt[1:0] = cnt_r[9:8];
				STCP_FLAGS_OFS: rdat_nxt[1:0] = {flag_p_r, flag_a_r};
				STCP_CLKDIV_OFS: rdat_nxt[7:0] = clkdiv_r;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl0_r <= STCP_CTRL0_RST;
			ctrl1_r <= STCP_CTRL1_RST;
			cmpa_r <= STCP_CMPA_RST;
			clkdiv_r <= STCP_CLKDIV_RST;
			cnt_r <= 10'h000;
			flag_a_r <= 1'b0;
			flag_p_r <= 1'b0;
			run_d_r <= 1'b0;
			pin_r <= 1'b0;
			pin_en_r <= 1'b0;
			ack_r <= 1'b0;
			err_r <= 1'b0;
			rdat_r <= 32'h0000_0000;
		end
		else
		begin
			ctrl0_r <= ctrl0_nxt;
			ctrl1_r <= ctrl1_nxt;
			cmpa_r <= cmpa_nxt;
			clkdiv_r <= clkdiv_nxt;
			cnt_r <= cnt_nxt;
			flag_a_r <= flag_a_nxt;
			flag_p_r <= flag_p_nxt;
			run_d_r <= run_d_nxt;
			pin_r <= pin_nxt;
			pin_en_r <= pin_en_nxt;
			ack_r <= ack_nxt;
			err_r <= err_nxt;
			rdat_r <= rdat_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign wb_dat_o = rdat_r;
	assign wb_ack_o = ack_r;
	assign wb_err_o = err_r;
	assign timer_out_o = pin_r;
	assign timer_out_en_o = pin_en_r;
	assign match_a_flag_o = flag_a_r;
	assign match_p_flag_o = flag_p_r;
endmodule : stcp_timer

// comparators A and P
module stcp_compare
	import stcp_pkg::*;
(
	stcp_tick_if.cmp tk // count and compare values
);
	logic [9:0] next_cnt;

	// count this tick brings; a clear on match replaces it, so period equals value
	assign next_cnt = tk.count + 10'h001;
	assign tk.match_a = (next_cnt == tk.cmp_a);
	assign tk.match_p = (next_cnt[9:7] == tk.cmp_p) && (next_cnt[6:0] == 7'h00) &&
		(tk.cmp_p != 3'h0);
endmodule : stcp_compare

// ### design/stcp_pkg.sv
// Purpose: constants for the compare/pwm timer
// Assumes: classic wishbone, 32-bit data, byte address
// Notes: register offsets are word aligned
package stcp_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] STCP_CTRL0_OFS = 8'h00;
	localparam logic [7:0] STCP_CTRL1_OFS = 8'h04;
	localparam logic [7:0] STCP_CMPA_LO_OFS = 8'h08;
	localparam logic [7:0] STCP_CMPA_HI_OFS = 8'h0c;
	localparam logic [7:0] STCP_CNT_LO_OFS = 8'h10;
	localparam logic [7:0] STCP_CNT_HI_OFS = 8'h14;
	localparam logic [7:0] STCP_FLAGS_OFS = 8'h18;
	localparam logic [7:0] STCP_CLKDIV_OFS = 8'h1c;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int STCP_RUN_BIT = 3;
	localparam int STCP_PVAL_LSB = 0;
	localparam int STCP_MODE_LSB = 6;
	localparam int STCP_FUNC_LSB = 4;
	localparam int STCP_OC_BIT = 3;
	localparam int STCP_POL_BIT = 2;
	localparam int STCP_SWAP_BIT = 1;
	localparam int STCP_CCLR_BIT = 0;
	localparam int STCP_FLAG_A_BIT = 0;
	localparam int STCP_FLAG_P_BIT = 1;
	localparam logic [7:0] STCP_CTRL0_RST = 8'h00;
	localparam logic [7:0] STCP_CTRL1_RST = 8'h00;
	localparam logic [9:0] STCP_CMPA_RST = 10'h000;
	localparam logic [7:0] STCP_CLKDIV_RST = 8'h00;
	localparam logic [9:0] STCP_CNT_MAX = 10'h3ff;
	localparam logic [9:0] STCP_PSTEP = 10'h080;
	// ----------------------------------------
	// modes and output functions
	// ----------------------------------------
	typedef enum logic [1:0] {
		STCP_MODE_CMP = 2'h0,
		STCP_MODE_CAP = 2'h1,
		STCP_MODE_PWM = 2'h2,
		STCP_MODE_TMR = 2'h3
	} stcp_mode_t;
	localparam logic [1:0] STCP_FN_NONE = 2'h0;
	localparam logic [1:0] STCP_FN_LOW = 2'h1;
	localparam logic [1:0] STCP_FN_HIGH = 2'h2;
	localparam logic [1:0] STCP_FN_TOG = 2'h3;
endpackage : stcp_pkg

// ### design/stcp_tick_if.sv
// Purpose: carries the counter tick and its match results between modules
// Assumes: single clock
// Notes: tick is a one-cycle enable
`timescale 1ns/1ns
interface stcp_tick_if;
	logic tick;
	logic [9:0] count;
	logic [9:0] cmp_a;
	logic [2:0] cmp_p;
	logic match_a;
	logic match_p;
	modport div (output tick);
	modport user (input tick, output count, output cmp_a, output cmp_p,
		input match_a, input match_p);
	modport cmp (input count, input cmp_a, input cmp_p, output match_a,
		output match_p);
endinterface : stcp_tick_if

// ### design/stcp_clkdiv.sv
// Purpose: module clock enable from the system clock
// Assumes: divide value 0 means every cycle
// Notes: stands in for the selectable counter clock source
`timescale 1ns/1ns
module stcp_clkdiv
	import stcp_pkg::*;
(
	input wire logic clk_i, // system clock
	input wire logic rst_i, // sync reset, high
	input wire logic [7:0] div_i, // cycles between ticks minus one
	stcp_tick_if.div tk // tick out
);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic tick_r;
	logic tick_nxt;

	always_comb
	begin
		tick_nxt = (cnt_r >= div_i);
		cnt_nxt = tick_nxt ? 8'h00 : cnt_r + 8'h01;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_r <= 8'h00;
			tick_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tk.tick = tick_r;
endmodule : stcp_clkdiv

// ### dv/stcp_timer_asserts.sv
// Purpose: port checks for the compare/pwm timer
// Assumes: one clock, sync reset high
// Notes: ctrl1 is shadowed from acked bus writes
`timescale 1ns/1ns
module stcp_timer_asserts
	import stcp_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic wb_cyc_i, // cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write
	input wire logic [7:0] wb_adr_i, // address
	input wire logic [3:0] wb_sel_i, // lanes
	input wire logic [31:0] wb_dat_i, // write data
	input wire logic [31:0] wb_dat_o, // read data
	input wire logic wb_ack_o, // ack
	input wire logic wb_err_o, // error
	input wire logic timer_out_o, // pin
	input wire logic timer_out_en_o, // pin enable
	input wire logic match_a_flag_o, // flag a
	input wire logic match_p_flag_o // flag p
);
	logic [7:0] c1_r;
	logic [7:0] c1_nxt;
	logic wr_fl;
	default clocking dcb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ----------------------------------------
	// ctrl1 shadow, as it stands this cycle
	// ----------------------------------------
	always_comb
	begin
		wr_fl = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == STCP_FLAGS_OFS;
		c1_nxt = c1_r;
		if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == STCP_CTRL1_OFS)
			c1_nxt = wb_dat_i[7:0];
	end
	always_ff @(posedge clk_i)
	begin
		c1_r <= rst_i ? STCP_CTRL1_RST : c1_nxt;
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_ack_pulse;
		wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_answer;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o;
	endproperty
	a_answer: assert property (p_answer) else $error("request not answered");
	property p_dat_idle;
		!wb_ack_o |-> wb_dat_o == 32'h0;
	endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
	property p_hi_byte;
		wb_ack_o && !wb_we_i && wb_adr_i == STCP_CMPA_HI_OFS |-> wb_dat_o[31:2] == 30'h0;
	endproperty
	a_hi_byte: assert property (p_hi_byte) else $error("high byte upper bits set");
	property p_fall_a;
		$fell(match_a_flag_o) |-> wr_fl && wb_dat_i[0];
	endproperty
	a_fall_a: assert property (p_fall_a) else $error("flag a dropped unasked");
	property p_fall_p;
		$fell(match_p_flag_o) |-> wr_fl && wb_dat_i[1];
	endproperty
	a_fall_p: assert property (p_fall_p) else $error("flag p dropped unasked");
	property p_en_mode;
		timer_out_en_o |-> !c1_nxt[6] || !$past(c1_nxt[6]);
	endproperty
	a_en_mode: assert property (p_en_mode) else $error("pin driven in timer mode");
	property p_p_flag;
		$rose(match_p_flag_o) |-> !(c1_nxt[0] && $past(c1_nxt[0]) && c1_nxt[7] == c1_nxt[6]);
	endproperty
	a_p_flag: assert property (p_p_flag) else $error("flag p with a-clear");
endmodule : stcp_timer_asserts
bind stcp_timer stcp_timer_asserts stcp_timer_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.wb_err_o(wb_err_o), .timer_out_o(timer_out_o), .timer_out_en_o(timer_out_en_o),
	.match_a_flag_o(match_a_flag_o), .match_p_flag_o(match_p_flag_o));

// ### dv/stcp_timer_tb_top.sv
// Purpose: directed bench for the compare/pwm timer
// Assumes: divider left at 0, one tick per clock
// Notes: pin sampled at rising edges
`timescale 1ns/1ns
module stcp_timer_tb_top
	import stcp_pkg::*;
;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, e;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic timer_out_o, timer_out_en_o, match_a_flag_o, match_p_flag_o;
	int failures, comparisons, on, per, chg;
	stcp_timer stcp_timer_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
		.timer_out_o(timer_out_o), .timer_out_en_o(timer_out_en_o),
		.match_a_flag_o(match_a_flag_o), .match_p_flag_o(match_p_flag_o));
	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// ----------------------------------------
	// bus and pin helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic step(inout int n);
		@(posedge clk_i);
		n++;
	endtask : step
	task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
		int n;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= {24'h000000, d};
		n = 0;
		step(n);
		while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50)
			step(n);
		q = wb_dat_o;
		e = wb_err_o;
		if (n >= 50)
			failures++;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic cfg(input logic [7:0] c1, input logic [7:0] c0, input logic [9:0] a);
		wb(1'b1, STCP_CTRL0_OFS, 8'h00);
		wb(1'b1, STCP_FLAGS_OFS, 8'h03);
		wb(1'b1, STCP_CTRL1_OFS, c1);
		wb(1'b1, STCP_CMPA_LO_OFS, a[7:0]);
		wb(1'b1, STCP_CMPA_HI_OFS, {6'h00, a[9:8]});
		wb(1'b1, STCP_CTRL0_OFS, c0);
		repeat (2) @(posedge clk_i);
	endtask : cfg
	task automatic meas(input logic lvl);
		int n;
		n = 0;
		while (timer_out_o === lvl && n < 3000)
			step(n);
		while (timer_out_o !== lvl && n < 3000)
			step(n);
		on = 0;
		while (timer_out_o === lvl && on < 3000)
			step(on);
		per = on;
		while (timer_out_o !== lvl && per < 3000)
			step(per);
	endtask : meas
	task automatic stay(input int cyc);
		logic p;
		p = timer_out_o;
		chg = 0;
		repeat (cyc)
		begin
			@(posedge clk_i);
			if (timer_out_o !== p)
				chg++;
			p = timer_out_o;
		end
	endtask : stay
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		wb(1'b0, STCP_CMPA_HI_OFS, 8'h00);
		chk(q, 32'h0);
		wb(1'b1, STCP_CMPA_HI_OFS, 8'hff);
		wb(1'b0, STCP_CMPA_HI_OFS, 8'h00);
		chk(q, 32'h3);
		wb(1'b0, 8'hfc, 8'h00);
		chk(e, 1);
	endtask : t_regs
	task automatic t_cmp();
		logic [7:0] c1s [2] = '{8'h39, 8'h38};
		int as [2] = '{200, 50};
		int ons [2] = '{200, 128};
		for (int i = 0; i < 2; i++)
		begin
			cfg(c1s[i], 8'h09, as[i][9:0]);
			chk(timer_out_o, 1);
			chk(timer_out_en_o, 1);
			meas(1'b1);
			chk(on, ons[i]);
			chk(per, 2 * ons[i]);
			chk(match_a_flag_o, 1);
			chk(match_p_flag_o, i);
		end
	endtask : t_cmp
	task automatic t_quiet();
		cfg(8'h31, 8'h09, 10'h000);
		chk(timer_out_o, 0);
		stay(2100);
		chk(chg, 0);
		chk(match_a_flag_o, 0);
		cfg(8'h09, 8'h09, 10'h014);
		stay(100);
		chk(chg, 0);
		chk(match_a_flag_o, 1);
		cfg(8'hf9, 8'h09, 10'h014);
		stay(100);
		chk(timer_out_en_o, 0);
		chk(chg, 0);
		chk(match_a_flag_o, 1);
		chk(match_p_flag_o, 0);
	endtask : t_quiet
	task automatic t_pwm();
		logic [7:0] c1s [5] = '{8'ha8, 8'haa, 8'ha0, 8'hac, 8'ha9};
		logic [7:0] c0s [5] = '{8'h0a, 8'h09, 8'h0a, 8'h0a, 8'h0a};
		int as [5] = '{64, 300, 64, 64, 64};
		int ons [5] = '{64, 128, 64, 64, 64};
		int pers [5] = '{256, 300, 256, 256, 256};
		for (int i = 0; i < 5; i++)
		begin
			cfg(c1s[i], c0s[i], as[i][9:0]);
			chk(timer_out_en_o, 1);
			meas(c1s[i][3] ^ c1s[i][2]);
			chk(on, ons[i]);
			chk(per, pers[i]);
			chk(match_a_flag_o, 1);
			chk(match_p_flag_o, 1);
		end
	endtask : t_pwm
	task automatic t_steady();
		logic [7:0] c1s [3] = '{8'ha8, 8'h88, 8'h98};
		logic [7:0] c0s [3] = '{8'h09, 8'h0a, 8'h0a};
		int as [3] = '{200, 64, 64};
		for (int i = 0; i < 3; i++)
		begin
			cfg(c1s[i], c0s[i], as[i][9:0]);
			stay(300);
			chk(chg, 0);
			chk(timer_out_o, i > 0 ? c1s[i][4] : 1'b1);
			chk(match_p_flag_o, 1);
		end
	endtask : t_steady
	task automatic t_hold();
		logic [31:0] held;
		cfg(8'hc0, 8'h08, 10'h000);
		repeat (100) @(posedge clk_i);
		wb(1'b1, STCP_CTRL0_OFS, 8'h00);
		wb(1'b0, STCP_CNT_LO_OFS, 8'h00);
		held = q;
		repeat (20) @(posedge clk_i);
		wb(1'b0, STCP_CNT_LO_OFS, 8'h00);
		chk(q, held);
		chk(held >= 32'h64, 1);
		wb(1'b1, STCP_CTRL0_OFS, 8'h08);
		wb(1'b0, STCP_CNT_LO_OFS, 8'h00);
		chk(q < 32'h8, 1);
	endtask : t_hold
	task automatic give_verdict();
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	initial
	begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		failures = 0;
		comparisons = 0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs();
		t_cmp();
		t_quiet();
		t_pwm();
		t_steady();
		t_hold();
		give_verdict();
	end
	initial
	begin
		repeat (60000) @(posedge clk_i);
		failures++;
		give_verdict();
	end
endmodule : stcp_timer_tb_top
